// [logic/tpom_pkg.sv]
// Constants shared by the test pattern and output word formatter
`default_nettype none
package tpom_pkg;

  // ==========================================================
  // Widths and sizes
  localparam int RES_W      = 18;
  localparam int TAG_W      = 2;
  localparam int WORD_W     = 24;
  localparam int PAD_W      = WORD_W - RES_W - TAG_W;
  localparam int GRP_CH     = 4;
  localparam int CHAN_N     = 8;
  localparam int REG_W      = 16;
  localparam int ADDR_W     = 10;
  localparam int FIFO_DEPTH = 4;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] LOWER_CTRL_IDX      = 8'h13;
  localparam logic [7:0] LOWER_ZERO_LOW_IDX  = 8'h14;
  localparam logic [7:0] LOWER_MIXED_IDX     = 8'h15;
  localparam logic [7:0] LOWER_ONE_HIGH_IDX  = 8'h16;
  localparam logic [7:0] UPPER_CTRL_IDX      = 8'h18;
  localparam logic [7:0] UPPER_ZERO_LOW_IDX  = 8'h19;
  localparam logic [7:0] UPPER_MIXED_IDX     = 8'h1A;
  localparam logic [7:0] UPPER_ONE_HIGH_IDX  = 8'h1B;
  localparam logic [7:0] CHANNEL_TAG_IDX     = 8'h1C;
  localparam logic [7:0] BLOCK_STATUS_IDX    = 8'h1D;

  // ==========================================================
  // Field positions and reset value
  localparam int INC_LSB      = 4;
  localparam int INC_W        = 4;
  localparam int SEL_LSB      = 2;
  localparam int SEL_W        = 2;
  localparam int EN_BIT       = 1;
  localparam int BYTE_W       = 8;
  localparam int TAG_UPPER_LSB = 8;
  localparam int TAG_LOWER_LSB = 0;
  localparam int ST_PHASE_LO  = 4;
  localparam int ST_PHASE_HI  = 5;
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

  // ==========================================================
  // Pattern selector codes
  localparam logic [SEL_W-1:0] SEL_FIXED0 = 2'h0;
  localparam logic [SEL_W-1:0] SEL_FIXED1 = 2'h1;
  localparam logic [SEL_W-1:0] SEL_RAMP   = 2'h2;
  localparam logic [SEL_W-1:0] SEL_ALT    = 2'h3;

endpackage : tpom_pkg
`default_nettype wire

// [logic/tpom_top.sv]
// Test pattern generator, tag insertion and output word FIFO
//
// Contract
// - Upper selector 0/1 outputs pattern zero
// - Upper selector 2 outputs digital ramp
// - Upper selector 3 alternates pattern zero/one
// - Ramp step is increment field plus one
// - Upper enable picks pattern over conversion
// - Upper pattern zero from 19h and 1Ah low
// - Upper pattern one from 1Ah high, 1Bh
// - Lower pattern one high bits in 16h
// - Tag byte high appended to channels 5-8
// - Tag byte low appended to channels 1-4
// - All registers reset to zero
// - Lower group has same selections, increment
// - Lower enable replaces channels 1-4 data
// - Lower pattern zero from 14h, 15h low
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Word FIFO
module tpom_fifo #(
  parameter int WIDTH = 192,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // Fill side
  input  wire logic                         in_valid,
  output logic                              in_ready,
  input  wire logic [WIDTH-1:0]             in_data,
  // Drain side
  output logic                              out_valid,
  input  wire logic                         out_ready,
  output logic [WIDTH-1:0]                  out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]        level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != FULL);
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign level     = count_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  fifo_bounds_a: assert property (@(posedge pclk) disable iff (!presetn)
    (push && !pop) |=> count_reg == $past(count_reg) + 1'b1 && count_reg <= FULL)
    else $error("fifo level did not rise on push");

endmodule : tpom_fifo

// ==========================================================
// One channel group: pattern choice, ramp, alternation, tags
module tpom_group
  import tpom_pkg::*;
(
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // Configuration
  input  wire logic [tpom_pkg::REG_W-1:0]    ctrl,
  input  wire logic [tpom_pkg::WORD_W-1:0]   pattern_zero,
  input  wire logic [tpom_pkg::WORD_W-1:0]   pattern_one,
  input  wire logic [tpom_pkg::BYTE_W-1:0]   tag_byte,
  // Sample path
  input  wire logic [tpom_pkg::GRP_CH*tpom_pkg::RES_W-1:0]  results,
  input  wire logic                          step,
  output logic [tpom_pkg::GRP_CH*tpom_pkg::WORD_W-1:0]      words,
  output logic                               phase
);
  import tpom_pkg::*;

  logic                 enable;
  logic [SEL_W-1:0]     select;
  logic [WORD_W-1:0]    inc_val;
  logic [WORD_W-1:0]    ramp_reg;
  logic                 phase_reg;
  logic [WORD_W-1:0]    pattern;

  assign enable  = ctrl[EN_BIT];
  assign select  = ctrl[SEL_LSB +: SEL_W];
  assign inc_val = {{(WORD_W-INC_W){1'b0}}, ctrl[INC_LSB +: INC_W]} + 24'h000001;
  assign phase   = phase_reg;

  // Ramp restarts at zero while disabled, wraps on overflow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ramp_reg <= '0;
    end
    else if (!enable)
    begin
      ramp_reg <= '0;
    end
    else if (step && select == SEL_RAMP)
    begin
      ramp_reg <= ramp_reg + inc_val;
    end
  end

  // Alternation phase flips once per accepted sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= 1'b0;
    end
    else if (!enable)
    begin
      phase_reg <= 1'b0;
    end
    else if (step && select == SEL_ALT)
    begin
      phase_reg <= ~phase_reg;
    end
  end

  always_comb
  begin
    case (select)
      SEL_RAMP:   pattern = ramp_reg;
      SEL_ALT:    pattern = phase_reg ? pattern_one : pattern_zero;
      SEL_FIXED0,
      SEL_FIXED1: pattern = pattern_zero;
      default:    pattern = pattern_zero;
    endcase
  end

  for (genvar ch = 0; ch < GRP_CH; ch++)
  begin : g_word
    // Result, then this channel's two tag bits, then zero padding
    assign words[ch*WORD_W +: WORD_W] = enable ? pattern :
      {results[ch*RES_W +: RES_W], tag_byte[ch*TAG_W +: TAG_W], {PAD_W{1'b0}}};
  end

  ramp_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (enable && select == SEL_RAMP && step) ##1 enable |->
      ramp_reg == $past(ramp_reg) + $past(inc_val))
    else $error("ramp did not advance by increment plus one");

  ramp_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> ramp_reg == '0 && phase_reg == 1'b0)
    else $error("ramp or phase not restarted while disabled");

  alt_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    (enable && select == SEL_ALT) |->
      words[WORD_W-1:0] == (phase_reg ? pattern_one : pattern_zero))
    else $error("alternating word wrong");

  alt_flip_a: assert property (@(posedge pclk) disable iff (!presetn)
    (enable && select == SEL_ALT && step) ##1 enable |-> phase_reg != $past(phase_reg))
    else $error("alternation phase did not flip");

  fixed_word_a: assert property (@(posedge pclk) disable iff (!presetn)
    (enable && !select[1]) |-> words[(GRP_CH-1)*WORD_W +: WORD_W] == pattern_zero)
    else $error("fixed pattern not shown");

  result_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |-> words[WORD_W-1 -: RES_W] == results[RES_W-1:0]
      && words[PAD_W +: TAG_W] == tag_byte[TAG_W-1:0])
    else $error("conversion result or tag not passed");

endmodule : tpom_group

// ==========================================================
// Top: APB registers, two groups, output FIFO
module tpom_top
  import tpom_pkg::*;
#(
  parameter int FIFO_DEPTH = tpom_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  // APB slave
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [tpom_pkg::ADDR_W-1:0]            paddr,
  input  wire logic [31:0]                            pwdata,
  output logic [31:0]                                 prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  // Conversion results in
  input  wire logic                                   sample_valid,
  output logic                                        sample_ready,
  input  wire logic [tpom_pkg::CHAN_N*tpom_pkg::RES_W-1:0]  sample_data,
  // Output words to host capture
  output logic                                        out_valid,
  input  wire logic                                   out_ready,
  output logic [tpom_pkg::CHAN_N*tpom_pkg::WORD_W-1:0]      out_data
);
  import tpom_pkg::*;

  localparam int FRAME_W = CHAN_N * WORD_W;
  localparam int HALF_R  = GRP_CH * RES_W;
  localparam int HALF_W  = GRP_CH * WORD_W;

  logic [REG_W-1:0] lower_group_pattern_control_reg;
  logic [REG_W-1:0] lower_group_pattern_zero_low_reg;
  logic [REG_W-1:0] lower_group_pattern_mixed_bytes_reg;
  logic [REG_W-1:0] lower_group_pattern_one_high_reg;
  logic [REG_W-1:0] upper_group_pattern_control_reg;
  logic [REG_W-1:0] upper_group_pattern_zero_low_reg;
  logic [REG_W-1:0] upper_group_pattern_mixed_bytes_reg;
  logic [REG_W-1:0] upper_group_pattern_one_high_reg;
  logic [REG_W-1:0] channel_tag_bits_reg;

  logic [7:0]       reg_idx;
  logic             aligned;
  logic             mapped;
  logic             wr_en;
  logic [REG_W-1:0] read_word;
  logic             step;
  logic             lower_phase;
  logic             upper_phase;
  logic [FRAME_W-1:0] frame;
  logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
  logic [WORD_W-1:0] lower_pattern_zero;
  logic [WORD_W-1:0] lower_pattern_one;
  logic [WORD_W-1:0] upper_pattern_zero;
  logic [WORD_W-1:0] upper_pattern_one;

  // ==========================================================
  // APB decode; zero wait states
  assign reg_idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite && mapped;

  always_comb
  begin
    mapped    = aligned;
    read_word = '0;
    case (reg_idx)
      LOWER_CTRL_IDX:     read_word = lower_group_pattern_control_reg;
      LOWER_ZERO_LOW_IDX: read_word = lower_group_pattern_zero_low_reg;
      LOWER_MIXED_IDX:    read_word = lower_group_pattern_mixed_bytes_reg;
      LOWER_ONE_HIGH_IDX: read_word = lower_group_pattern_one_high_reg;
      UPPER_CTRL_IDX:     read_word = upper_group_pattern_control_reg;
      UPPER_ZERO_LOW_IDX: read_word = upper_group_pattern_zero_low_reg;
      UPPER_MIXED_IDX:    read_word = upper_group_pattern_mixed_bytes_reg;
      UPPER_ONE_HIGH_IDX: read_word = upper_group_pattern_one_high_reg;
      CHANNEL_TAG_IDX:    read_word = channel_tag_bits_reg;
      BLOCK_STATUS_IDX:
      begin
        read_word              = REG_W'(fifo_level);
        read_word[ST_PHASE_LO] = lower_phase;
        read_word[ST_PHASE_HI] = upper_phase;
      end
      default:            mapped = 1'b0;
    endcase
  end

  assign prdata  = (psel && !pwrite && mapped) ? {16'h0000, read_word} : 32'h00000000;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // Register file; status index is read only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lower_group_pattern_control_reg     <= REG_RESET;
      lower_group_pattern_zero_low_reg    <= REG_RESET;
      lower_group_pattern_mixed_bytes_reg <= REG_RESET;
      lower_group_pattern_one_high_reg    <= REG_RESET;
      upper_group_pattern_control_reg     <= REG_RESET;
      upper_group_pattern_zero_low_reg    <= REG_RESET;
      upper_group_pattern_mixed_bytes_reg <= REG_RESET;
      upper_group_pattern_one_high_reg    <= REG_RESET;
      channel_tag_bits_reg                <= REG_RESET;
    end
    else if (wr_en)
    begin
      case (reg_idx)
        LOWER_CTRL_IDX:     lower_group_pattern_control_reg     <= pwdata[REG_W-1:0];
        LOWER_ZERO_LOW_IDX: lower_group_pattern_zero_low_reg    <= pwdata[REG_W-1:0];
        LOWER_MIXED_IDX:    lower_group_pattern_mixed_bytes_reg <= pwdata[REG_W-1:0];
        LOWER_ONE_HIGH_IDX: lower_group_pattern_one_high_reg    <= pwdata[REG_W-1:0];
        UPPER_CTRL_IDX:     upper_group_pattern_control_reg     <= pwdata[REG_W-1:0];
        UPPER_ZERO_LOW_IDX: upper_group_pattern_zero_low_reg    <= pwdata[REG_W-1:0];
        UPPER_MIXED_IDX:    upper_group_pattern_mixed_bytes_reg <= pwdata[REG_W-1:0];
        UPPER_ONE_HIGH_IDX: upper_group_pattern_one_high_reg    <= pwdata[REG_W-1:0];
        CHANNEL_TAG_IDX:    channel_tag_bits_reg                <= pwdata[REG_W-1:0];
        default:            ;
      endcase
    end
  end

  // ==========================================================
  // Pattern assembly from register pieces
  assign lower_pattern_zero = {lower_group_pattern_mixed_bytes_reg[BYTE_W-1:0],
                               lower_group_pattern_zero_low_reg};
  assign lower_pattern_one  = {lower_group_pattern_one_high_reg,
                               lower_group_pattern_mixed_bytes_reg[REG_W-1:BYTE_W]};
  assign upper_pattern_zero = {upper_group_pattern_mixed_bytes_reg[BYTE_W-1:0],
                               upper_group_pattern_zero_low_reg};
  assign upper_pattern_one  = {upper_group_pattern_one_high_reg,
                               upper_group_pattern_mixed_bytes_reg[REG_W-1:BYTE_W]};

  // ==========================================================
  // Groups work independently; settings sampled per accepted sample
  assign step = sample_valid && sample_ready;

  tpom_group u_lower (
    .pclk         (pclk),
    .presetn      (presetn),
    .ctrl         (lower_group_pattern_control_reg),
    .pattern_zero (lower_pattern_zero),
    .pattern_one  (lower_pattern_one),
    .tag_byte     (channel_tag_bits_reg[TAG_LOWER_LSB +: BYTE_W]),
    .results      (sample_data[HALF_R-1:0]),
    .step         (step),
    .words        (frame[HALF_W-1:0]),
    .phase        (lower_phase)
  );

  tpom_group u_upper (
    .pclk         (pclk),
    .presetn      (presetn),
    .ctrl         (upper_group_pattern_control_reg),
    .pattern_zero (upper_pattern_zero),
    .pattern_one  (upper_pattern_one),
    .tag_byte     (channel_tag_bits_reg[TAG_UPPER_LSB +: BYTE_W]),
    .results      (sample_data[2*HALF_R-1:HALF_R]),
    .step         (step),
    .words        (frame[2*HALF_W-1:HALF_W]),
    .phase        (upper_phase)
  );

  tpom_fifo #(
    .WIDTH (FRAME_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (frame),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data),
    .level     (fifo_level)
  );

  reg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && aligned && reg_idx == UPPER_CTRL_IDX) |=>
      upper_group_pattern_control_reg == $past(pwdata[REG_W-1:0]))
    else $error("control write not stored");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && (reg_idx > BLOCK_STATUS_IDX || !aligned)) |-> pslverr && pready)
    else $error("unmapped access not flagged");

  upper_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (upper_group_pattern_control_reg[EN_BIT] && !upper_group_pattern_control_reg[SEL_LSB+1]) |->
      frame[FRAME_W-1 -: WORD_W] == upper_pattern_zero)
    else $error("channel 8 not fixed pattern zero");

  upper_ramp_a: assert property (@(posedge pclk) disable iff (!presetn)
    (upper_group_pattern_control_reg[EN_BIT]
      && upper_group_pattern_control_reg[SEL_LSB +: SEL_W] == SEL_RAMP)
      ##1 !upper_group_pattern_control_reg[EN_BIT] |=>
      frame[FRAME_W-1 -: WORD_W] != $past(frame[FRAME_W-1 -: WORD_W], 2)
      || sample_data[CHAN_N*RES_W-1 -: RES_W] == frame[FRAME_W-1 -: RES_W])
    else $error("upper ramp or return to results failed");

endmodule : tpom_top
`default_nettype wire

// [tb/tpom_host.sv]
// Host capture model: takes output frames, can stall
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Capture side
module tpom_host
  import tpom_pkg::*;
(
  // Clock and reset
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  // Frame stream
  input  wire logic                                  out_valid,
  output var logic                                   out_ready,
  input  wire logic [tpom_pkg::CHAN_N*tpom_pkg::WORD_W-1:0] out_data,
  // Bench control
  input  wire logic                                  stall
);
  logic [CHAN_N*WORD_W-1:0] got[$];

  // Ready moves only after an edge; frames queued in arrival order
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_ready <= 1'b0;
    else
    begin
      out_ready <= !stall;
      if (out_valid && out_ready)
        got.push_back(out_data);
    end
  end
endmodule : tpom_host
`default_nettype wire

// [tb/test_pattern_output_mux_bench.sv]
// Self-checking bench for the pattern formatter
`timescale 1ns/1ps
`default_nettype none
module test_pattern_output_mux_bench;
  import tpom_pkg::*;
  // ==========================================================
  // Signals and expected patterns
  localparam logic [15:0] TAGS = 16'hA5C3;
  localparam logic [23:0] PL0  = 24'h331111;
  localparam logic [23:0] PL1  = 24'h445522;
  localparam logic [23:0] PU0  = 24'h561234;
  localparam logic [23:0] PU1  = 24'h789ABB;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0]        paddr;
  logic [31:0]              pwdata, prdata, rd;
  logic                     sample_valid, sample_ready, out_valid, out_ready, stall;
  logic [CHAN_N*RES_W-1:0]  sample_data;
  logic [CHAN_N*WORD_W-1:0] out_data;
  int                       n_fail, total_checks, n;
  logic [7:0]  ridx [7] = '{LOWER_ZERO_LOW_IDX, LOWER_MIXED_IDX, LOWER_ONE_HIGH_IDX,
                            UPPER_ZERO_LOW_IDX, UPPER_MIXED_IDX, UPPER_ONE_HIGH_IDX, CHANNEL_TAG_IDX};
  logic [15:0] rval [7] = '{16'h1111, 16'h2233, 16'h4455, 16'h1234, 16'hBB56, 16'h789A, TAGS};

  always #2 pclk = ~pclk;

  tpom_top #(.FIFO_DEPTH(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  tpom_host i_host (.pclk(pclk), .presetn(presetn), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .stall(stall));

  // ==========================================================
  // Helpers
  task automatic finish_test();
    $display("Checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic bail();
    n_fail++;
    $display("[FAIL] %0t wait timed out", $time);
    finish_test();
  endtask : bail

  task automatic chk(input logic [191:0] got, input logic [191:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    int t = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      t++;
      if (t > 50) bail();
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [7:0] idx, input logic [15:0] e, input logic e_err);
    apb(1'b0, idx, 16'h0000);
    chk(192'(rd), 192'(e), "read");
    chk(192'(err), 192'(e_err), "error flag");
  endtask : rchk

  task automatic send(input logic [143:0] d);
    int t = 0;
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample_data  <= d;
    do
    begin
      @(negedge pclk);
      t++;
      if (t > 50) bail();
    end
    while (sample_ready !== 1'b1);
    @(posedge pclk);
    sample_valid <= 1'b0;
  endtask : send

  task automatic getf(input logic [191:0] e);
    int t = 0;
    while (i_host.got.size() == 0)
    begin
      @(posedge pclk);
      t++;
      if (t > 50) bail();
    end
    chk(i_host.got.pop_front(), e, "frame");
  endtask : getf

  function automatic logic [143:0] mkd(input int k);
    logic [143:0] d;
    for (int c = 0; c < 8; c++)
      d[c*18+:18] = 18'h20000 + 18'(k*16 + c);
    return d;
  endfunction : mkd

  function automatic logic [191:0] frm(input int k, input logic [1:0] en, input logic [23:0] pl,
                                       input logic [23:0] pu);
    logic [191:0] f;
    logic [143:0] d;
    logic [7:0]   tb;
    d = mkd(k);
    for (int c = 0; c < 8; c++)
    begin
      tb = (c < 4) ? TAGS[7:0] : TAGS[15:8];
      f[c*24+:24] = en[c/4] ? ((c < 4) ? pl : pu) : {d[c*18+:18], tb[(c%4)*2+:2], 4'h0};
    end
    return f;
  endfunction : frm

  // ==========================================================
  // Main sequence
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    sample_valid = 0;
    sample_data = '0;
    stall = 0;
    n_fail = 0;
    total_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ridx[i]) rchk(ridx[i], 16'h0000, 1'b0);
    rchk(LOWER_CTRL_IDX, 16'h0000, 1'b0);
    rchk(UPPER_CTRL_IDX, 16'h0000, 1'b0);
    rchk(BLOCK_STATUS_IDX, 16'h0000, 1'b0);
    rchk(8'h17, 16'h0000, 1'b1);
    foreach (ridx[i])
    begin
      apb(1'b1, ridx[i], rval[i]);
      rchk(ridx[i], rval[i], 1'b0);
    end
    send(mkd(0));
    getf(frm(0, 2'b00, 0, 0));
    apb(1'b1, UPPER_CTRL_IDX, 16'h0002);
    send(mkd(1));
    getf(frm(1, 2'b10, 0, PU0));
    apb(1'b1, UPPER_CTRL_IDX, 16'h0006);
    apb(1'b1, LOWER_CTRL_IDX, 16'h0006);
    send(mkd(2));
    getf(frm(2, 2'b11, PL0, PU0));
    apb(1'b1, LOWER_CTRL_IDX, 16'h000E);
    apb(1'b1, UPPER_CTRL_IDX, 16'h000E);
    for (n = 0; n < 3; n++)
    begin
      send(mkd(n));
      getf(frm(n, 2'b11, n[0] ? PL1 : PL0, n[0] ? PU1 : PU0));
    end
    apb(1'b1, LOWER_CTRL_IDX, 16'h0000);
    apb(1'b1, UPPER_CTRL_IDX, 16'h0000);
    apb(1'b1, LOWER_CTRL_IDX, 16'h000A);
    apb(1'b1, UPPER_CTRL_IDX, 16'h00FA);
    for (n = 0; n < 3; n++)
    begin
      send(mkd(n));
      getf(frm(n, 2'b11, 24'(n), 24'(n*16)));
    end
    apb(1'b1, UPPER_CTRL_IDX, 16'h0000);
    apb(1'b1, UPPER_CTRL_IDX, 16'h00FA);
    send(mkd(5));
    getf(frm(5, 2'b11, 24'h000003, 24'h000000));
    apb(1'b1, LOWER_CTRL_IDX, 16'h0000);
    apb(1'b1, UPPER_CTRL_IDX, 16'h0000);
    // Fill the buffer against a stalled host, then drain it
    @(posedge pclk);
    stall <= 1'b1;
    repeat (2) @(posedge pclk);
    n = 0;
    sample_valid <= 1'b1;
    sample_data  <= mkd(8);
    while (n < 10)
    begin
      @(negedge pclk);
      if (sample_ready !== 1'b1) break;
      @(posedge pclk);
      n++;
      sample_data <= mkd(8 + n);
    end
    @(posedge pclk);
    sample_valid <= 1'b0;
    chk(192'(n), 192'(4), "fill count");
    apb(1'b0, BLOCK_STATUS_IDX, 16'h0000);
    chk(192'(rd[15:0]), 192'(4), "fill level");
    @(posedge pclk);
    stall <= 1'b0;
    for (n = 0; n < 4; n++)
      getf(frm(8 + n, 2'b00, 0, 0));
    finish_test();
  end
endmodule : test_pattern_output_mux_bench
`default_nettype wire
